// file: logic/die_temp_pkg.sv
// Package: register map, field layout and constants of the die-temperature block
package die_temp_pkg;
  // Register indices (printed offsets are not all multiples of four)
  localparam logic [13:0] IDX_REF_TEMP = 14'h0011;
  localparam logic [13:0] IDX_GAIN = 14'h002E;
  localparam logic [13:0] IDX_SRC_SEL = 14'h0038;
  localparam logic [13:0] IDX_RAW_TEMP = 14'h0054;
  localparam logic [13:0] IDX_FUSE_SEL = 14'h20FD;
  localparam logic [13:0] IDX_FUSE_RD = 14'h20FF;
  localparam logic [13:0] IDX_REL_TEMP = 14'h0060;
  localparam logic [13:0] IDX_LIN_COEF = 14'h0061;
  localparam logic [13:0] IDX_QUAD_COEF = 14'h0062;
  localparam logic [13:0] IDX_ZC_COUNT = 14'h0063;
  localparam int ADDR_LSB = 2;
  localparam int ADDR_W = 16;

  // Scale factors by variant
  localparam logic [15:0] SCALE_POLY = 16'h58C1;
  localparam logic [15:0] SCALE_SINGLE = 16'h2571;

  // Compensation source selector codes
  localparam logic [31:0] SRC_INTERNAL = 32'h0000_0000;
  localparam logic [31:0] SRC_EXTERNAL = 32'h0000_000F;

  // Fuse selector codes
  localparam logic [7:0] FSEL_SLOPE = 8'h04;
  localparam logic [7:0] FSEL_BGA = 8'h05;
  localparam logic [7:0] FSEL_BGB = 8'h06;

  // Reset values
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [31:0] GAIN_UNITY = 32'h0000_4000;
  // Gain shift of the coefficient products
  localparam int LIN_SHIFT = 14;
  localparam int QUAD_SHIFT = 28;
endpackage

// file: logic/die_temp_gain_compensation.sv
// Die-temperature path, gain correction, fuse readback and zero-cross count
// Function
// (R1) Raw sensor sample stored at its word
// (R2) Relative temp = (reference - raw) * scale
// (R3) Scale 22721 poly-phase, 9585 single-phase
// (R4) Result unit is a tenth of a degree
// (R5) Fuse select 4/5/6 drives fuse readback
// (R6) Source zero: engine computes gain correction
// (R7) Source 15: software gain word applied
// (R8) Count zero crossings, two per period
// (R9) Other source values behave like zero
//
// Register access over APB was decided locally.
`timescale 1ns/100ps
module die_temp_gain_compensation #(
  parameter bit POLY_PHASE = 1'b1,
  parameter int TEMP_W = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [die_temp_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic temp_valid,
  input wire logic [TEMP_W-1:0] temp_sample,
  input wire logic [2:0] slope_fuse_bits,
  input wire logic [7:0] bandgap_fuse_a,
  input wire logic [7:0] bandgap_fuse_b,
  input wire logic line_sign,
  output logic [31:0] gain_out,
  output logic [31:0] rel_temp_out
);
  import die_temp_pkg::*;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic [31:0] ref_temp_r, gain_r, src_sel_r, raw_temp_r, rel_temp_r;
  logic [31:0] lin_coef_r, quad_coef_r, zc_count_r;
  logic [7:0] fuse_sel_r;
  logic [2:0] ls_sync_r;
  logic ls_state_r;

  wire [13:0] idx = paddr[ADDR_W-1:ADDR_LSB];
  wire access = psel & penable;
  wire wr = access & pwrite;
  wire hit_ref = idx == IDX_REF_TEMP;
  wire hit_gain = idx == IDX_GAIN;
  wire hit_src = idx == IDX_SRC_SEL;
  wire hit_raw = idx == IDX_RAW_TEMP;
  wire hit_fsel = idx == IDX_FUSE_SEL;
  wire hit_frd = idx == IDX_FUSE_RD;
  wire hit_rel = idx == IDX_REL_TEMP;
  wire hit_lin = idx == IDX_LIN_COEF;
  wire hit_quad = idx == IDX_QUAD_COEF;
  wire hit_zc = idx == IDX_ZC_COUNT;
  wire mapped = hit_ref | hit_gain | hit_src | hit_raw | hit_fsel |
                hit_frd | hit_rel | hit_lin | hit_quad | hit_zc;
  wire ro_hit = hit_raw | hit_frd | hit_rel | hit_zc;

  assign pready = 1'b1;
  assign pslverr = access & (~mapped | (pwrite & ro_hit));

  // ----------------------------------------------------------------
  // Temperature arithmetic
  // ----------------------------------------------------------------
  wire [15:0] scale = POLY_PHASE ? SCALE_POLY : SCALE_SINGLE; // R3
  wire signed [32:0] diff = $signed({ref_temp_r[31], ref_temp_r}) -
                            $signed({raw_temp_r[31], raw_temp_r});
  wire signed [49:0] prod = diff * $signed({1'b0, scale});
  // Product scaled to tenths of a degree by the scale constant
  wire [31:0] rel_nxt = prod[31:0]; // R2 R4

  wire internal_src = src_sel_r != SRC_EXTERNAL; // R9
  wire signed [63:0] lin_term = $signed(lin_coef_r) * $signed(rel_temp_r);
  wire signed [63:0] t_sq = $signed(rel_temp_r) * $signed(rel_temp_r);
  wire signed [95:0] quad_term = $signed(quad_coef_r) * t_sq;
  wire [31:0] lin_s = 32'(lin_term >>> LIN_SHIFT);
  wire [31:0] quad_s = 32'(quad_term >>> QUAD_SHIFT);
  wire [31:0] gain_nxt = GAIN_UNITY + lin_s + quad_s; // R6

  wire [7:0] fuse_val = fuse_sel_r == FSEL_SLOPE ?
                          {5'b0_0000, slope_fuse_bits} :
                        fuse_sel_r == FSEL_BGA ? bandgap_fuse_a :
                        fuse_sel_r == FSEL_BGB ? bandgap_fuse_b :
                        RST_BYTE; // R5

  // Zero crossing: each agreed change of the synced sign is one crossing
  wire ls_agree = ls_sync_r[1] == ls_sync_r[2];
  wire zc_event = ls_agree & (ls_sync_r[2] != ls_state_r); // R8

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_temp_r <= RST_WORD;
      src_sel_r <= RST_WORD;
      lin_coef_r <= RST_WORD;
      quad_coef_r <= RST_WORD;
      fuse_sel_r <= RST_BYTE;
    end else if (wr) begin
      if (hit_ref) ref_temp_r <= pwdata;
      if (hit_src) src_sel_r <= pwdata;
      if (hit_lin) lin_coef_r <= pwdata;
      if (hit_quad) quad_coef_r <= pwdata;
      if (hit_fsel) fuse_sel_r <= pwdata[7:0]; // R5
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      raw_temp_r <= RST_WORD;
    end else if (temp_valid) begin
      raw_temp_r <= 32'(signed'(temp_sample)); // R1
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rel_temp_r <= RST_WORD;
    end else begin
      rel_temp_r <= rel_nxt; // R2
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gain_r <= GAIN_UNITY;
    end else if (internal_src) begin
      gain_r <= gain_nxt; // R6 R9
    end else if (wr && hit_gain) begin
      gain_r <= pwdata; // R7
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ls_sync_r <= 3'b000;
      ls_state_r <= 1'b0;
      zc_count_r <= RST_WORD;
    end else begin
      ls_sync_r <= {ls_sync_r[1:0], line_sign};
      if (zc_event) begin
        ls_state_r <= ls_sync_r[2];
        zc_count_r <= zc_count_r + 32'h0000_0001; // R8
      end
    end
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  wire [31:0] rd_mux = hit_ref ? ref_temp_r :
                       hit_gain ? gain_r :
                       hit_src ? src_sel_r :
                       hit_raw ? raw_temp_r :
                       hit_fsel ? {24'h00_0000, fuse_sel_r} :
                       hit_frd ? {24'h00_0000, fuse_val} :
                       hit_rel ? rel_temp_r :
                       hit_lin ? lin_coef_r :
                       hit_quad ? quad_coef_r :
                       hit_zc ? zc_count_r : RST_WORD;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= RST_WORD;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rd_mux;
    end
  end

  assign gain_out = gain_r;
  assign rel_temp_out = rel_temp_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_raw_store;
    @(posedge pclk) disable iff (!presetn)
      temp_valid |=> raw_temp_r == 32'(signed'($past(temp_sample)));
  endproperty
  a_raw_store: assert property (p_raw_store) else $error("raw not stored"); // R1

  property p_rel_calc;
    @(posedge pclk) disable iff (!presetn)
      ##1 rel_temp_r == $past(rel_nxt);
  endproperty
  a_rel_calc: assert property (p_rel_calc) else $error("rel temp wrong"); // R2

  property p_scale;
    @(posedge pclk) scale == (POLY_PHASE ? 16'd22721 : 16'd9585);
  endproperty
  a_scale: assert property (p_scale) else $error("scale wrong"); // R3

  property p_fuse;
    @(posedge pclk) disable iff (!presetn)
      fuse_sel_r == FSEL_BGA |-> fuse_val == bandgap_fuse_a;
  endproperty
  a_fuse: assert property (p_fuse) else $error("fuse readback wrong"); // R5

  property p_internal;
    @(posedge pclk) disable iff (!presetn)
      src_sel_r == SRC_INTERNAL |=> gain_r == $past(gain_nxt);
  endproperty
  a_internal: assert property (p_internal) else $error("gain not computed"); // R6

  property p_external;
    @(posedge pclk) disable iff (!presetn)
      src_sel_r == SRC_EXTERNAL && !(wr && hit_gain) |=> $stable(gain_r);
  endproperty
  a_external: assert property (p_external) else $error("gain moved"); // R7

  property p_zc;
    @(posedge pclk) disable iff (!presetn)
      zc_event |=> zc_count_r == $past(zc_count_r) + 32'h0000_0001;
  endproperty
  a_zc: assert property (p_zc) else $error("crossing not counted"); // R8

  property p_other;
    @(posedge pclk) disable iff (!presetn)
      src_sel_r != SRC_EXTERNAL |=> gain_r == $past(gain_nxt);
  endproperty
  a_other: assert property (p_other) else $error("other src not internal"); // R9

  property p_raw_hold;
    @(posedge pclk) disable iff (!presetn)
      !temp_valid |=> $stable(raw_temp_r);
  endproperty
  a_raw_hold: assert property (p_raw_hold) else $error("raw moved"); // R1

  property p_raw_refuse;
    @(posedge pclk) disable iff (!presetn)
      wr && hit_raw |-> pslverr;
  endproperty
  a_raw_refuse: assert property (p_raw_refuse) else $error("raw write taken"); // R1

  property p_fuse_slope;
    @(posedge pclk) disable iff (!presetn)
      fuse_sel_r == FSEL_SLOPE |-> fuse_val == {5'b0_0000, slope_fuse_bits};
  endproperty
  a_fuse_slope: assert property (p_fuse_slope) else $error("slope fuse"); // R5

  property p_fuse_bgb;
    @(posedge pclk) disable iff (!presetn)
      fuse_sel_r == FSEL_BGB |-> fuse_val == bandgap_fuse_b;
  endproperty
  a_fuse_bgb: assert property (p_fuse_bgb) else $error("bandgap b fuse"); // R5

  property p_fuse_none;
    @(posedge pclk) disable iff (!presetn)
      fuse_sel_r != FSEL_SLOPE && fuse_sel_r != FSEL_BGA &&
      fuse_sel_r != FSEL_BGB |-> fuse_val == RST_BYTE;
  endproperty
  a_fuse_none: assert property (p_fuse_none) else $error("fuse not zero"); // R5

  property p_fsel_write;
    @(posedge pclk) disable iff (!presetn)
      wr && hit_fsel |=>
        ({24'h00_0000, fuse_sel_r} == ($past(pwdata) & 32'h0000_00FF));
  endproperty
  a_fsel_write: assert property (p_fsel_write) else $error("fsel write"); // R5

  sequence s_sw_gain_write;
    src_sel_r == SRC_EXTERNAL && wr && hit_gain;
  endsequence

  property p_gain_write;
    @(posedge pclk) disable iff (!presetn)
      s_sw_gain_write |=> gain_r == $past(pwdata);
  endproperty
  a_gain_write: assert property (p_gain_write) else $error("gain write"); // R7

  property p_zc_idle;
    @(posedge pclk) disable iff (!presetn)
      !zc_event |=> $stable(zc_count_r);
  endproperty
  a_zc_idle: assert property (p_zc_idle) else $error("spurious count"); // R8

  sequence s_sign_change;
    ls_sync_r[1] == ls_sync_r[2] && ls_sync_r[2] != ls_state_r;
  endsequence

  property p_zc_track;
    @(posedge pclk) disable iff (!presetn)
      s_sign_change |=> ls_state_r != $past(ls_state_r);
  endproperty
  a_zc_track: assert property (p_zc_track) else $error("sign not tracked"); // R8

  property p_rd_load;
    @(posedge pclk) disable iff (!presetn)
      psel && !penable && !pwrite |=> prdata == $past(rd_mux);
  endproperty
  a_rd_load: assert property (p_rd_load) else $error("read not loaded"); // R5

  property p_rd_hold;
    @(posedge pclk) disable iff (!presetn)
      !(psel && !penable && !pwrite) |=> $stable(prdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved"); // R5
endmodule

// file: verification/fw_master.sv
// Firmware-side APB master model of the microcontroller
`timescale 1ns/100ps
module fw_master (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [15:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  logic err;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 16'h0000;
    pwdata = 32'h0000_0000;
    err = 1'b0;
  end
  // One transfer, held until pready is seen high
  task automatic xfer(input logic w, input logic [13:0] idx,
      input logic [31:0] wd, output logic [31:0] rd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released bus lines stop showing the old request
    paddr <= ~{idx, 2'b00};
    pwdata <= ~wd;
  endtask
endmodule

// file: verification/die_temp_gain_compensation_tb.sv
// Self-checking bench of the die-temperature block
`timescale 1ns/100ps
module die_temp_gain_compensation_tb;
  import die_temp_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr;
  logic [15:0] paddr, raw_w, x;
  logic [31:0] pwdata, prdata, gain_out, rel_temp_out, rd, ref_w, lin_w, f;
  logic temp_valid = 1'b0;
  logic [15:0] temp_sample = 16'h0000;
  logic [2:0] slope_fuse_bits = 3'h0;
  logic [7:0] bandgap_fuse_a = 8'h00;
  logic [7:0] bandgap_fuse_b = 8'h00;
  logic line_sign = 1'b0;
  logic [15:0] lfsr_r = 16'h000a;
  logic [31:0] codes [3] = '{32'h0000_0000, 32'h0000_0003, 32'h0000_000F};
  int fail_count = 0;
  int tests_run = 0;
  always #5 pclk = ~pclk;
  fw_master fw (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr);
  die_temp_gain_compensation dut (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .temp_valid, .temp_sample,
    .slope_fuse_bits, .bandgap_fuse_a, .bandgap_fuse_b, .line_sign,
    .gain_out, .rel_temp_out);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [15:0] rnd();
    lfsr_r = {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
    return lfsr_r;
  endfunction
  function automatic logic [31:0] exp_rel(logic [31:0] r, logic [15:0] s);
    return (r - {{16{s[15]}}, s}) * 32'd22721;
  endfunction
  function automatic logic [31:0] exp_gain(logic [31:0] l, logic [31:0] r);
    logic signed [63:0] p;
    p = $signed(l) * $signed(r);
    return 32'h0000_4000 + 32'(p >>> 14);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [13:0] i, input logic [31:0] d);
    fw.xfer(1'b1, i, d, rd);
  endtask
  task automatic rdw(input logic [13:0] i);
    fw.xfer(1'b0, i, 32'h0000_0000, rd);
  endtask
  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #200000;
    fail_count++;
    wrap_up();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(gain_out, 32'h0000_4000);
    for (int i = 0; i < 3; i++) begin
      raw_w = (i == 0) ? 16'h0000 : rnd();
      raw_w = {{8{raw_w[7]}}, raw_w[7:0]};
      ref_w = {24'h0, 8'(rnd())};
      @(posedge pclk);
      temp_sample <= raw_w;
      temp_valid <= 1'b1;
      slope_fuse_bits <= 3'(rnd());
      bandgap_fuse_a <= 8'(rnd());
      bandgap_fuse_b <= 8'(rnd());
      @(posedge pclk);
      temp_valid <= 1'b0;
      wr(IDX_REF_TEMP, ref_w);
      rdw(IDX_RAW_TEMP);
      chk(rd, {{16{raw_w[15]}}, raw_w});
      repeat (2) @(posedge pclk);
      chk(rel_temp_out, exp_rel(ref_w, raw_w));
    end
    $display("Test temperature path done");
    x = rnd();
    lin_w = {{24{x[7]}}, x[7:0]};
    wr(IDX_LIN_COEF, lin_w);
    wr(IDX_QUAD_COEF, 32'h0000_0000);
    foreach (codes[k]) begin
      wr(IDX_SRC_SEL, codes[k]);
      wr(IDX_GAIN, 32'h0000_1234);
      repeat (3) @(posedge pclk);
      f = (k == 2) ? 32'h0000_1234 : exp_gain(lin_w, exp_rel(ref_w, raw_w));
      chk(gain_out, f);
    end
    $display("Test gain source done");
    for (int c = 4; c < 8; c++) begin
      wr(IDX_FUSE_SEL, 32'(c));
      rdw(IDX_FUSE_RD);
      f = (c == 4) ? {29'h0, slope_fuse_bits} : 32'h0000_0000;
      f = (c == 5) ? {24'h0, bandgap_fuse_a} : f;
      f = (c == 6) ? {24'h0, bandgap_fuse_b} : f;
      chk(rd, f);
    end
    $display("Test fuse readback done");
    wr(IDX_RAW_TEMP, 32'h0000_0001);
    chk({31'h0, fw.err}, 32'h0000_0001);
    rdw(14'h0100);
    chk({31'h0, fw.err}, 32'h0000_0001);
    chk(rd, 32'h0000_0000);
    rdw(IDX_ZC_COUNT);
    f = rd + 32'h0000_0004;
    repeat (4) begin
      @(posedge pclk);
      line_sign <= ~line_sign;
      repeat (10) @(posedge pclk);
    end
    rdw(IDX_ZC_COUNT);
    chk(rd, f);
    $display("Test refusal and zero crossings done");
    wrap_up();
  end
endmodule
